// File: arir_host.sv
/* host model for the register port
   assumes requests launch on the falling clock edge */
`timescale 1ns/100ps
module arir_host (
  input  wire logic        clock_i,
  input  wire logic [15:0] rdata_i,
  output logic      [6:0]  addr_o = 7'h00,
  output logic             write_o = 1'b0,
  output logic      [15:0] wdata_o = 16'h0000,
  output logic             read_o = 1'b0
);
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    write_o = 1'b1;
    @(negedge clock_i);
    write_o = 1'b0;
    // released data flips so a stale value never passes
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clock_i);
    addr_o = a;
    read_o = 1'b1;
    @(negedge clock_i);
    read_o = 1'b0;
    d = rdata_i;
  endtask
endmodule

// File: arir_pkg.sv
/*
  Package for the conversion result and ideality adjust register bank:
  register addresses, field positions, reset values and formats.
  Assumes a 7-bit register address and 16-bit data as seen on the serial port.
*/
package arir_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [6:0] ARIR_ADDR_IDEAL_0 = 7'h21;
  localparam logic [6:0] ARIR_ADDR_IDEAL_1 = 7'h22;
  localparam logic [6:0] ARIR_ADDR_RES_FIRST = 7'h23;
  localparam logic [6:0] ARIR_ADDR_RES_LAST = 7'h32;
  localparam int ARIR_NUM_CHANNELS = 16;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int ARIR_RESULT_BITS = 12;
  localparam int ARIR_CODE_BITS = 8;
  localparam logic [7:0] ARIR_CODE_RESET = 8'h00;
  localparam logic [7:0] ARIR_CODE_MAX = 8'h7f;
  localparam logic [7:0] ARIR_CODE_MIN = 8'h80;
  localparam logic [11:0] ARIR_RESULT_RESET = 12'h000;
  // two's complement offset: flips the msb of an offset-binary sample
  localparam logic [11:0] ARIR_DIFF_FLIP = 12'h800;

  typedef enum logic [1:0] {
    ARIR_KIND_NONE,
    ARIR_KIND_IDEAL,
    ARIR_KIND_RESULT
  } arir_kind_type;

endpackage

// File: arir_regs.sv
/*
  Conversion result and ideality adjust register bank.
  Holds sixteen read-only channel results and two ideality adjust codes,
  reached through a simple register port fed by the serial interface logic.
  Assumes the serial front end and the converter sit on CLOCK_I.
*/
// Notes on behaviour
// - adjust code is signed eight bits, default zero
// - results read-only at 0x23 to 0x32
// - channel n result at 0x23 plus n
// - sixteen-bit word, value low twelve, top zero
// - single-ended channel 0 stored straight binary
// - adjust uses low byte, high ignored
// - differential channel 0 stored two's complement
`timescale 1ns/100ps
module arir_regs
  import arir_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic [6:0]  REG_ADDR_I,
  input  wire logic        REG_WRITE_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_READ_I,
  output logic      [15:0] REG_RDATA_O,
  output logic             REG_HIT_O,
  input  wire logic        CONV_VALID_I,
  input  wire logic [3:0]  CONV_CHANNEL_I,
  input  wire logic [11:0] CONV_DATA_I,
  input  wire logic        CH0_DIFF_I,
  output logic      [7:0]  IDEALITY_CODE_0_O,
  output logic      [7:0]  IDEALITY_CODE_1_O,
  output logic      [8:0]  EFFECTIVE_IDEALITY_0_O,
  output logic      [8:0]  EFFECTIVE_IDEALITY_1_O
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic arir_kind_type decode(input logic [6:0] addr);
    if (addr == ARIR_ADDR_IDEAL_0 || addr == ARIR_ADDR_IDEAL_1) begin
      decode = ARIR_KIND_IDEAL;
    end else if (addr >= ARIR_ADDR_RES_FIRST && addr <= ARIR_ADDR_RES_LAST) begin
      decode = ARIR_KIND_RESULT;
    end else begin
      decode = ARIR_KIND_NONE;
    end
  endfunction

  // signed code plus 256: code 0 sits at 0x100 and the order is kept
  function automatic logic [8:0] ideality_index(input logic [7:0] code);
    ideality_index = {~code[7], code};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [11:0]   result_q [ARIR_NUM_CHANNELS];
  logic [11:0]   result_d [ARIR_NUM_CHANNELS];
  logic [7:0]    ideal0_q;
  logic [7:0]    ideal0_d;
  logic [7:0]    ideal1_q;
  logic [7:0]    ideal1_d;
  logic [8:0]    eff0_q;
  logic [8:0]    eff0_d;
  logic [8:0]    eff1_q;
  logic [8:0]    eff1_d;
  logic [15:0]   rdata_q;
  logic [15:0]   rdata_d;
  logic [11:0]   fmt_data;
  logic [11:0]   store_data;
  logic [3:0]    rd_index;
  arir_kind_type kind;

  assign kind = decode(REG_ADDR_I);
  assign rd_index = 4'(REG_ADDR_I - ARIR_ADDR_RES_FIRST);

  arir_result_fmt u_fmt (
    .raw_i  (CONV_DATA_I),
    .diff_i (CH0_DIFF_I),
    .fmt_o  (fmt_data)
  );

  // only channel 0 carries the pair result; others stay straight binary
  assign store_data = (CONV_CHANNEL_I == 4'h0) ? fmt_data : CONV_DATA_I;

  // ----------------------------------------------------------------------
  // result store
  // ----------------------------------------------------------------------
  always_comb begin
    for (int n = 0; n < ARIR_NUM_CHANNELS; n++) begin
      result_d[n] = result_q[n];
    end
    // host writes never reach this path
    if (CONV_VALID_I) begin
      result_d[CONV_CHANNEL_I] = store_data;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int n = 0; n < ARIR_NUM_CHANNELS; n++) begin
        result_q[n] <= ARIR_RESULT_RESET;
      end
    end else begin
      for (int n = 0; n < ARIR_NUM_CHANNELS; n++) begin
        result_q[n] <= result_d[n];
      end
    end
  end

  // ----------------------------------------------------------------------
  // ideality adjust codes
  // ----------------------------------------------------------------------
  always_comb begin
    ideal0_d = ideal0_q;
    ideal1_d = ideal1_q;
    if (REG_WRITE_I && REG_ADDR_I == ARIR_ADDR_IDEAL_0) begin
      ideal0_d = REG_WDATA_I[7:0];
    end
    if (REG_WRITE_I && REG_ADDR_I == ARIR_ADDR_IDEAL_1) begin
      ideal1_d = REG_WDATA_I[7:0];
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ideal0_q <= ARIR_CODE_RESET;
      ideal1_q <= ARIR_CODE_RESET;
    end else begin
      ideal0_q <= ideal0_d;
      ideal1_q <= ideal1_d;
    end
  end

  // ----------------------------------------------------------------------
  // effective ideality index
  // ----------------------------------------------------------------------
  // built from the next code so index and code always change together
  always_comb begin
    eff0_d = ideality_index(ideal0_d);
    eff1_d = ideality_index(ideal1_d);
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      eff0_q <= {~ARIR_CODE_RESET[7], ARIR_CODE_RESET};
      eff1_q <= {~ARIR_CODE_RESET[7], ARIR_CODE_RESET};
    end else begin
      eff0_q <= eff0_d;
      eff1_q <= eff1_d;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // read data is registered; unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (REG_READ_I) begin
      case (kind)
        ARIR_KIND_IDEAL: begin
          rdata_d = {8'h00, (REG_ADDR_I == ARIR_ADDR_IDEAL_0) ? ideal0_q : ideal1_q};
        end
        ARIR_KIND_RESULT: begin
          rdata_d = {4'h0, result_q[rd_index]};
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_O = rdata_q;
  assign REG_HIT_O = (kind != ARIR_KIND_NONE);
  assign IDEALITY_CODE_0_O = ideal0_q;
  assign IDEALITY_CODE_1_O = ideal1_q;
  assign EFFECTIVE_IDEALITY_0_O = eff0_q;
  assign EFFECTIVE_IDEALITY_1_O = eff1_q;

endmodule

// File: arir_regs_monitor.sv
/* checker for the result and adjust bank ports
   assumes one clock, bound onto arir_regs */
`timescale 1ns/100ps
module arir_regs_monitor (
  input wire logic        CLOCK_I,
  input wire logic        RESET_I,
  input wire logic [6:0]  REG_ADDR_I,
  input wire logic        REG_WRITE_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic        REG_READ_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic        REG_HIT_O,
  input wire logic        CONV_VALID_I,
  input wire logic [3:0]  CONV_CHANNEL_I,
  input wire logic [11:0] CONV_DATA_I,
  input wire logic        CH0_DIFF_I,
  input wire logic [7:0]  IDEALITY_CODE_0_O,
  input wire logic [8:0]  EFFECTIVE_IDEALITY_0_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  sequence ch0_read(d);
    CONV_VALID_I && CONV_CHANNEL_I == 4'h0 && CH0_DIFF_I == d ##1
    REG_READ_I && REG_ADDR_I == 7'h23;
  endsequence
  plain_format_a: assert property (
    ch0_read(1'b0) |=> REG_RDATA_O == {4'h0, $past(CONV_DATA_I, 2)})
    else $error("single-ended channel 0 result wrong");
  diff_format_a: assert property (
    ch0_read(1'b1) |=> REG_RDATA_O == {4'h0, $past(CONV_DATA_I, 2) ^ 12'h800})
    else $error("differential channel 0 result wrong");
  top_zero_a: assert property (
    REG_READ_I |=> REG_RDATA_O[15:12] == 4'h0) else $error("top bits not zero");
  hit_decode_a: assert property (
    REG_HIT_O == (REG_ADDR_I >= 7'h21 && REG_ADDR_I <= 7'h32)) else $error("decode wrong");
  code_write_a: assert property (
    REG_WRITE_I && REG_ADDR_I == 7'h21 |=>
    {8'h00, IDEALITY_CODE_0_O} == ($past(REG_WDATA_I) & 16'h00ff))
    else $error("adjust code not from low byte");
  code_hold_a: assert property (
    !(REG_WRITE_I && REG_ADDR_I == 7'h21) |=> $stable(IDEALITY_CODE_0_O))
    else $error("adjust code changed without write");
  ideality_map_a: assert property (
    $signed({1'b0, EFFECTIVE_IDEALITY_0_O}) == 256 + $signed(IDEALITY_CODE_0_O))
    else $error("effective ideality index wrong");
endmodule
bind arir_regs arir_regs_monitor monitor (.*);

// File: arir_regs_tb.sv
/* self-checking bench for the result and adjust bank
   assumes arir_host drives the register port */
`timescale 1ns/100ps
module arir_regs_tb;
  import arir_pkg::*;
  logic        clk, rst, wr, rd, hit, cv, diff;
  logic [6:0]  addr;
  logic [15:0] wd, rdata, rv;
  logic [3:0]  ch;
  logic [11:0] cd;
  logic [7:0]  code0, code1;
  logic [8:0]  eff0, eff1;
  logic [7:0]  codes [3] = '{ARIR_CODE_MAX, ARIR_CODE_MIN, ARIR_CODE_RESET};
  int          num_errors, check_count, cyc, model [16];
  int          seed = 26;
  arir_regs uut (.CLOCK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WRITE_I(wr),
    .REG_WDATA_I(wd), .REG_READ_I(rd), .REG_RDATA_O(rdata), .REG_HIT_O(hit),
    .CONV_VALID_I(cv), .CONV_CHANNEL_I(ch), .CONV_DATA_I(cd), .CH0_DIFF_I(diff),
    .IDEALITY_CODE_0_O(code0), .IDEALITY_CODE_1_O(code1),
    .EFFECTIVE_IDEALITY_0_O(eff0), .EFFECTIVE_IDEALITY_1_O(eff1));
  arir_host host (.clock_i(clk), .rdata_i(rdata), .addr_o(addr), .write_o(wr),
    .wdata_o(wd), .read_o(rd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic conv(input int c, input logic d);
    @(negedge clk);
    {cv, ch, diff, cd} = {1'b1, 4'(c), d, 12'($random(seed))};
    model[c] = (c == 0 && d) ? cd ^ 12'h800 : cd;
    @(negedge clk);
    cv = 1'b0;
    cd = ~cd;
  endtask
  task automatic check_all();
    for (int n = 0; n < 16; n++) begin
      host.rd(ARIR_ADDR_RES_FIRST + 7'(n), rv);
      chk(rv, 16'(model[n]));
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (++cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {rst, cv, ch, cd, diff} = {1'b1, 18'h0};
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check_all();
    chk({code0, code1}, {ARIR_CODE_RESET, ARIR_CODE_RESET});
    chk({7'h00, eff0}, 16'(256 + $signed(ARIR_CODE_RESET)));
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++)
        conv(c, p[0]);
      check_all();
      fork
        conv(0, p[0]);
        begin
          @(negedge clk);
          host.rd(ARIR_ADDR_RES_FIRST, rv);
        end
      join
      chk(rv, 16'(model[0]));
    end
    foreach (codes[i]) begin
      host.wr(ARIR_ADDR_IDEAL_0, {8'($random(seed)), codes[i]});
      host.wr(ARIR_ADDR_IDEAL_1, {8'($random(seed)), ~codes[i]});
      chk({code0, code1}, {codes[i], ~codes[i]});
      chk({7'h00, eff0}, 16'(256 + $signed(codes[i])));
      chk({7'h00, eff1}, 16'(256 + $signed(~codes[i])));
      host.rd(ARIR_ADDR_IDEAL_0, rv);
      chk(rv, {8'h00, codes[i]});
      chk(16'(hit), 16'h0001);
      host.rd(ARIR_ADDR_IDEAL_1, rv);
      chk(rv, {8'h00, ~codes[i]});
    end
    for (int n = 0; n < 16; n++)
      host.wr(ARIR_ADDR_RES_FIRST + 7'(n), 16'($random(seed)));
    check_all();
    chk({code0, code1}, {codes[2], ~codes[2]});
    host.rd(7'h33, rv);
    chk(rv, 16'h0000);
    chk(16'(hit), 16'h0000);
    results();
  end
endmodule

// File: arir_result_fmt.sv
/*
  Result formatter: maps a raw 12-bit offset-binary sample onto the stored
  format for its channel.
  Assumes the converter delivers samples in offset binary for both modes.
*/
`timescale 1ns/100ps
module arir_result_fmt
  import arir_pkg::*;
(
  input  wire logic [11:0] raw_i,
  input  wire logic        diff_i,
  output logic      [11:0] fmt_o
);

  // ----------------------------------------------------------------------
  // format selection
  // ----------------------------------------------------------------------
  // single-ended keeps straight binary; a pair becomes two's complement
  always_comb begin
    if (diff_i) begin
      fmt_o = raw_i ^ ARIR_DIFF_FLIP;
    end else begin
      fmt_o = raw_i;
    end
  end

endmodule
